// *** design/tgc_timer_ctrl.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module tgc_timer_ctrl
    import tgc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    input wire logic [CH_N-1:0] timer_event,
    input wire logic idle_mode,
    output logic irq,
    output logic [1:0] timer_run,
    output logic [1:0] counter_clear,
    output logic prescaler_run,
    output logic channels_active,
    output logic pair_16bit,
    output logic cascade_24,
    output logic cascade_32,
    output logic [1:0] pair_operating_mode,
    output logic compare_double_buffer_en,
    output logic pair_enable
);
    typedef struct packed {
        logic [CH_N-1:0] flags;
        logic [CH_N-1:0] mask;
        logic pair_en;
        logic [DATA_W-1:0] run;
        logic [DATA_W-1:0] mode;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic [1:0] timer_run;
        logic [1:0] clear;
        logic presc_run;
        logic active;
        logic p16;
        logic c24;
        logic c32;
        logic dbuf;
    } tgc_state_s;

    tgc_state_s q;
    tgc_state_s d;
    logic [1:0] casc_d;
    logic [1:0] opm_d;

    always_comb begin
        d = q;
        d.rdata = READ_ZERO;
        if (rd_en) begin
            unique case (addr)
                ADDR_IRQ_STATUS: begin
                    // Upper bits undefined; zero keeps reads deterministic
                    d.rdata = {4'h0, q.flags}; // [R2] [R3]
                    d.flags = RST_FLAGS; // [R2]
                end
                ADDR_IRQ_MASK: begin
                    d.rdata = {4'h0, q.mask}; // [R4]
                end
                ADDR_PAIR_CTRL: begin
                    d.rdata = {q.pair_en, 7'h00};
                end
                ADDR_RUN_CTRL: begin
                    // Bit 4 has no storage and reads zero
                    if (q.pair_en) begin
                        d.rdata = q.run & RUN_RW_MASK; // [R12]
                    end
                end
                ADDR_PAIR_MODE: begin
                    if (q.pair_en) begin
                        d.rdata = q.mode;
                    end
                end
                default: begin
                    d.rdata = READ_ZERO;
                end
            endcase
        end
        if (wr_en) begin
            unique case (addr)
                ADDR_IRQ_CLEAR: begin
                    d.flags = q.flags & ~wdata[CH_N-1:0];
                end
                ADDR_IRQ_MASK: begin
                    d.mask = wdata[CH_N-1:0];
                end
                ADDR_PAIR_CTRL: begin
                    d.pair_en = wdata[CTRL_EN_BIT];
                end
                ADDR_RUN_CTRL: begin
                    // Disabled pair is unclocked; settings are held
                    if (q.pair_en) begin
                        d.run = wdata & RUN_RW_MASK; // [R14]
                    end
                end
                ADDR_PAIR_MODE: begin
                    if (q.pair_en) begin
                        d.mode = wdata; // [R14]
                    end
                end
                default: begin
                end
            endcase
        end
        // Event in the clearing cycle is kept: set beats clear
        d.flags = d.flags | timer_event; // [R1] [R2]
        d.irq = |(d.flags & ~d.mask); // [R1]
        d.active = ~idle_mode | d.run[RUN_IDLE_BIT]; // [R7]
        d.timer_run[0] = d.run[RUN_LOW_BIT] & d.active; // [R5]
        d.timer_run[1] = d.run[RUN_HIGH_BIT] & d.active; // [R5]
        d.clear[0] = ~d.run[RUN_LOW_BIT]; // [R5]
        d.clear[1] = ~d.run[RUN_HIGH_BIT]; // [R5]
        d.presc_run = d.run[RUN_PRESC_BIT] & d.active; // [R6]
        casc_d = d.run[RUN_CASC_MSB:RUN_CASC_LSB];
        opm_d = d.mode[MODE_OP_MSB:MODE_OP_LSB];
        d.c24 = (casc_d == CASC_24); // [R9]
        d.c32 = (casc_d == CASC_32); // [R10]
        // Reserved cascade code falls back to the uncascaded pair
        d.p16 = (opm_d == OPM_16) && !d.c24 && !d.c32; // [R8] [R13] [R15]
        d.dbuf = d.run[RUN_DBUF_BIT]; // [R11]
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0; // [R16]
            q.flags <= RST_FLAGS;
            q.mask <= RST_MASK;
            q.pair_en <= RST_PAIR_EN;
            q.run <= RST_RUN;
            q.mode <= RST_MODE;
            q.clear <= RST_CLEAR;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign irq = q.irq;
    assign timer_run = q.timer_run;
    assign counter_clear = q.clear;
    assign prescaler_run = q.presc_run;
    assign channels_active = q.active;
    assign pair_16bit = q.p16;
    assign cascade_24 = q.c24;
    assign cascade_32 = q.c32;
    assign pair_operating_mode = q.mode[MODE_OP_MSB:MODE_OP_LSB]; // [R13]
    assign compare_double_buffer_en = q.dbuf;
    assign pair_enable = q.pair_en;

    property p_masked_no_irq;
        @(posedge ref_clk) disable iff (!rst_n)
        ((q.flags & ~q.mask) == 4'h0) |-> !irq;
    endproperty
    a_masked_no_irq: assert property (p_masked_no_irq) // [R1]
        else $error("Interrupt raised with only masked flags");

    property p_masked_flag_sets;
        @(posedge ref_clk) disable iff (!rst_n)
        (timer_event[0] && q.mask[0] && !(wr_en && addr == ADDR_IRQ_MASK))
            |=> (q.flags[0] && !(irq && q.flags == 4'h1));
    endproperty
    a_masked_flag_sets: assert property (p_masked_flag_sets) // [R1]
        else $error("Masked event lost its flag or raised interrupt");

    property p_read_clears;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_IRQ_STATUS && timer_event == 4'h0)
            |=> (q.flags == 4'h0 && rdata[3:0] == $past(q.flags))
            ##1 ($past(rd_en) || rdata == READ_ZERO);
    endproperty
    a_read_clears: assert property (p_read_clears) // [R2]
        else $error("Status read did not return and clear flags");

    property p_status_upper;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_IRQ_STATUS) |=> (rdata[7:4] == 4'h0);
    endproperty
    a_status_upper: assert property (p_status_upper) // [R3]
        else $error("Status upper bits not zero");

    property p_mask_read;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_IRQ_MASK) |=> (rdata == {4'h0, $past(q.mask)});
    endproperty
    a_mask_read: assert property (p_mask_read) // [R4]
        else $error("Mask read wrong");

    property p_stop_clears;
        @(posedge ref_clk) disable iff (!rst_n)
        !q.run[RUN_LOW_BIT] |-> (counter_clear[0] && !timer_run[0]);
    endproperty
    a_stop_clears: assert property (p_stop_clears) // [R5]
        else $error("Stopped low timer not held clear");

    property p_prescaler;
        @(posedge ref_clk) disable iff (!rst_n)
        prescaler_run |-> (q.run[RUN_PRESC_BIT] && channels_active);
    endproperty
    a_prescaler: assert property (p_prescaler) // [R6]
        else $error("Prescaler runs without its run bit");

    property p_idle_off;
        @(posedge ref_clk) disable iff (!rst_n)
        (idle_mode && !wr_en && !q.run[RUN_IDLE_BIT]) |=> (!channels_active && timer_run == 2'h0);
    endproperty
    a_idle_off: assert property (p_idle_off) // [R7]
        else $error("Channels still active in idle");

    property p_cascade;
        @(posedge ref_clk) disable iff (!rst_n)
        (cascade_24 == (q.run[6:5] == CASC_24)) && (cascade_32 == (q.run[6:5] == CASC_32))
            && !(pair_16bit && (cascade_24 || cascade_32));
    endproperty
    a_cascade: assert property (p_cascade) // [R8] [R9] [R10] [R15]
        else $error("Cascade outputs disagree with run register");

    property p_disabled_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_RUN_CTRL && !pair_enable) |=> $stable(q.run);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) // [R14]
        else $error("Run register written while pair disabled");

    property p_run_read_bit4;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_RUN_CTRL) |=> !rdata[4];
    endproperty
    a_run_read_bit4: assert property (p_run_read_bit4) // [R12]
        else $error("Run bit 4 read nonzero");

    property p_dbuf;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_RUN_CTRL && pair_enable)
            |=> (compare_double_buffer_en == $past(wdata[RUN_DBUF_BIT]));
    endproperty
    a_dbuf: assert property (p_dbuf) // [R11]
        else $error("Double buffer enable not taken from bit 7");

    property p_irq_follows;
        @(posedge ref_clk) disable iff (!rst_n)
        (timer_event[2] && !q.mask[2] && !(wr_en && addr == ADDR_IRQ_MASK)) |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) // [R1]
        else $error("Unmasked event raised no interrupt");

    property p_masked_quiet;
        @(posedge ref_clk) disable iff (!rst_n)
        (timer_event != 4'h0 && (timer_event & ~q.mask) == 4'h0
            && (q.flags & ~q.mask) == 4'h0 && !wr_en) |=> !irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) // [R1]
        else $error("Masked events raised interrupt");

    property p_read_set_wins;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_IRQ_STATUS) |=> (q.flags == $past(timer_event));
    endproperty
    a_read_set_wins: assert property (p_read_set_wins) // [R2]
        else $error("Status read lost an event or kept old flags");

    property p_clear_write;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_IRQ_CLEAR)
            |=> (q.flags == (($past(q.flags) & ~$past(wdata[3:0])) | $past(timer_event)));
    endproperty
    a_clear_write: assert property (p_clear_write) // [R1]
        else $error("Clear write gave wrong flags");

    property p_flags_sticky;
        @(posedge ref_clk) disable iff (!rst_n)
        (!(rd_en && addr == ADDR_IRQ_STATUS) && !(wr_en && addr == ADDR_IRQ_CLEAR))
            |=> (q.flags == ($past(q.flags) | $past(timer_event)));
    endproperty
    a_flags_sticky: assert property (p_flags_sticky) // [R1]
        else $error("Flags changed without event, read or clear");

    property p_mask_write;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_IRQ_MASK) |=> (q.mask == $past(wdata[3:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) // [R4]
        else $error("Mask write not stored");

    property p_run_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_RUN_CTRL && pair_enable)
            |=> (counter_clear == ~$past(wdata[1:0]));
    endproperty
    a_run_clear: assert property (p_run_clear) // [R5]
        else $error("Counter clear does not follow run bits");

    property p_run_start;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_RUN_CTRL && pair_enable && !idle_mode)
            |=> (timer_run == $past(wdata[1:0]));
    endproperty
    a_run_start: assert property (p_run_start) // [R5]
        else $error("Timer run does not follow run bits");

    property p_presc_start;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_RUN_CTRL && pair_enable && !idle_mode)
            |=> (prescaler_run == $past(wdata[RUN_PRESC_BIT]));
    endproperty
    a_presc_start: assert property (p_presc_start) // [R6]
        else $error("Prescaler run does not follow bit 2");

    property p_idle_keep;
        @(posedge ref_clk) disable iff (!rst_n)
        (q.run[RUN_IDLE_BIT] && !(wr_en && addr == ADDR_RUN_CTRL)) |=> channels_active;
    endproperty
    a_idle_keep: assert property (p_idle_keep) // [R7]
        else $error("Channels stopped although idle operation is on");

    property p_mode_write;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_PAIR_MODE && pair_enable)
            |=> (pair_operating_mode == $past(wdata[MODE_OP_MSB:MODE_OP_LSB]));
    endproperty
    a_mode_write: assert property (p_mode_write) // [R13]
        else $error("Operating mode not taken from mode write");

    property p_mode_read;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && addr == ADDR_PAIR_MODE && pair_enable) |=> (rdata == $past(q.mode));
    endproperty
    a_mode_read: assert property (p_mode_read) // [R13]
        else $error("Mode register read wrong");

    property p_disabled_read;
        @(posedge ref_clk) disable iff (!rst_n)
        (rd_en && (addr == ADDR_RUN_CTRL || addr == ADDR_PAIR_MODE) && !pair_enable)
            |=> (rdata == READ_ZERO);
    endproperty
    a_disabled_read: assert property (p_disabled_read) // [R14]
        else $error("Disabled pair register read nonzero");

    property p_mode_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_en && addr == ADDR_PAIR_MODE && !pair_enable) |=> $stable(q.mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) // [R14]
        else $error("Mode register written while pair disabled");

    property p_rdata_idle;
        @(posedge ref_clk) disable iff (!rst_n)
        !rd_en |=> (rdata == READ_ZERO);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // [R2]
        else $error("Read data not zero outside read cycle");

    property p_pair16;
        @(posedge ref_clk) disable iff (!rst_n)
        (q.mode[MODE_OP_MSB:MODE_OP_LSB] == OPM_16 && !wr_en
            && q.run[RUN_CASC_MSB:RUN_CASC_LSB] == CASC_NONE) |=> pair_16bit;
    endproperty
    a_pair16: assert property (p_pair16) // [R8]
        else $error("Uncascaded 16-bit mode not selected");
endmodule : tgc_timer_ctrl

// *** design/tgc_pkg.sv ***
// Contract
// [R1] Masked channel sets flag, no interrupt request
// [R2] Status read returns flags, then clears them
// [R3] Status upper four bits undefined on read
// [R4] Mask upper four bits undefined on read
// [R5] Run bits 0/1: count, or stop-and-clear
// [R6] Run bit 2 runs shared prescaler
// [R7] Run bit 3 keeps channels on in idle
// [R8] Cascade 00: 8-bit pair or 16-bit
// [R9] Cascade 01: low timer after preceding pair
// [R10] Cascade 10: all four channels, 32 bits
// [R11] Run bit 7 enables compare double buffering
// [R12] Run bit 4 unused, undefined on read
// [R13] Mode 00/01/10/11: 8-bit, 16-bit, PPG, PWM
// [R14] Enable pair before touching other pair registers
// [R15] Cascade 11 reserved, behaves as uncascaded
// [R16] Reset clears masks, flags and run fields
package tgc_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CH_N = 4;

    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 32'hFFFF_F110;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 32'hFFFF_F113;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 32'hFFFF_F114;
    localparam logic [ADDR_W-1:0] ADDR_PAIR_CTRL = 32'hFFFF_F11A;
    localparam logic [ADDR_W-1:0] ADDR_RUN_CTRL = 32'hFFFF_F11B;
    localparam logic [ADDR_W-1:0] ADDR_PAIR_MODE = 32'hFFFF_F11F;

    localparam int unsigned RUN_LOW_BIT = 0;
    localparam int unsigned RUN_HIGH_BIT = 1;
    localparam int unsigned RUN_PRESC_BIT = 2;
    localparam int unsigned RUN_IDLE_BIT = 3;
    localparam int unsigned RUN_CASC_LSB = 5;
    localparam int unsigned RUN_CASC_MSB = 6;
    localparam int unsigned RUN_DBUF_BIT = 7;
    localparam logic [DATA_W-1:0] RUN_RW_MASK = 8'hEF;
    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned MODE_OP_LSB = 6;
    localparam int unsigned MODE_OP_MSB = 7;

    localparam logic [1:0] CASC_NONE = 2'h0;
    localparam logic [1:0] CASC_24 = 2'h1;
    localparam logic [1:0] CASC_32 = 2'h2;
    localparam logic [1:0] OPM_TWO_8 = 2'h0;
    localparam logic [1:0] OPM_16 = 2'h1;
    localparam logic [1:0] OPM_PPG = 2'h2;
    localparam logic [1:0] OPM_PWM = 2'h3;

    localparam logic [CH_N-1:0] RST_FLAGS = 4'h0;
    localparam logic [CH_N-1:0] RST_MASK = 4'h0;
    localparam logic [DATA_W-1:0] RST_RUN = 8'h00;
    localparam logic [DATA_W-1:0] RST_MODE = 8'h00;
    localparam logic RST_PAIR_EN = 1'b0;
    localparam logic [1:0] RST_CLEAR = 2'h3;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
endpackage : tgc_pkg

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    import tgc_pkg::*;
    logic ref_clk, rst_n, wr_en, rd_en, idle_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rv;
    logic [CH_N-1:0] timer_event;
    logic irq, prescaler_run, channels_active, pair_16bit, cascade_24, cascade_32;
    logic compare_double_buffer_en, pair_enable;
    logic [1:0] timer_run, counter_clear, pair_operating_mode;
    int err_total, checks;
    tgc_timer_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer_event(timer_event),
        .idle_mode(idle_mode), .irq(irq), .timer_run(timer_run),
        .counter_clear(counter_clear), .prescaler_run(prescaler_run),
        .channels_active(channels_active), .pair_16bit(pair_16bit),
        .cascade_24(cascade_24), .cascade_32(cascade_32),
        .pair_operating_mode(pair_operating_mode),
        .compare_double_buffer_en(compare_double_buffer_en), .pair_enable(pair_enable));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic pulse(input logic [3:0] ev);
        @(posedge ref_clk);
        timer_event <= ev;
        @(posedge ref_clk);
        timer_event <= 4'h0;
        settle();
    endtask : pulse
    function automatic logic [7:0] runs();
        return {2'b00, timer_run, counter_clear, prescaler_run, channels_active};
    endfunction : runs
    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    initial begin
        #(25 * 4000);
        err_total++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        idle_mode = 1'b0;
        addr = '0;
        wdata = '0;
        timer_event = '0;
        err_total = 0;
        checks = 0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
        chk("outputs", 8'h0D, runs());
        chk("irq", 8'h00, {7'b0, irq});
        rd(ADDR_IRQ_MASK, rv);
        chk("mask", 8'h00, rv & 8'h0F);
        rd(ADDR_IRQ_STATUS, rv);
        chk("status", 8'h00, rv & 8'h0F);
        $display("test reset done");
        // Pair still off, so this write must not land
        wr(ADDR_RUN_CTRL, 8'h07);
        settle();
        chk("disabled run", 8'h0D, runs());
        wr(ADDR_PAIR_CTRL, 8'h80);
        settle();
        chk("pair_enable", 8'h01, {7'b0, pair_enable});
        rd(ADDR_RUN_CTRL, rv);
        chk("run reg", 8'h00, rv & RUN_RW_MASK);
        $display("test enable done");
        wr(ADDR_RUN_CTRL, 8'h07);
        settle();
        chk("run all", 8'h33, runs());
        wr(ADDR_RUN_CTRL, 8'h01);
        settle();
        chk("run low", 8'h19, runs());
        wr(ADDR_RUN_CTRL, 8'h07);
        idle_mode <= 1'b1;
        settle();
        chk("idle off", 8'h00, runs());
        wr(ADDR_RUN_CTRL, 8'h1F);
        settle();
        chk("idle on", 8'h33, runs());
        idle_mode <= 1'b0;
        $display("test run done");
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_PAIR_MODE, 8'(m << 6));
            settle();
            chk("mode", 8'(m), {6'b0, pair_operating_mode});
            rd(ADDR_PAIR_MODE, rv);
            chk("mode reg", 8'(m << 6), rv);
        end
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_RUN_CTRL, 8'(c << 5) | 8'h80);
            wr(ADDR_PAIR_MODE, 8'h40);
            settle();
            rv = {5'b0, pair_16bit, cascade_24, cascade_32};
            if (c < 3) begin
                chk("cascade", 8'h04 >> c, rv);
            end else begin
                chk("cascade rsv", 8'h00, rv & 8'h03);
            end
            chk("dbuf", 8'h01, {7'b0, compare_double_buffer_en});
            rd(ADDR_RUN_CTRL, rv);
            chk("run readback", 8'(c << 5) | 8'h80, rv & RUN_RW_MASK);
        end
        // Disabled pair hides and holds run and mode settings
        wr(ADDR_PAIR_CTRL, 8'h00);
        rd(ADDR_RUN_CTRL, rv);
        chk("run hidden", 8'h00, rv);
        chk("pair off", 8'h00, {7'b0, pair_enable});
        wr(ADDR_PAIR_MODE, 8'hC0);
        rd(ADDR_PAIR_MODE, rv);
        chk("mode hidden", 8'h00, rv);
        wr(ADDR_PAIR_CTRL, 8'h80);
        rd(ADDR_RUN_CTRL, rv);
        chk("run held", 8'hE0, rv & RUN_RW_MASK);
        chk("mode held", 8'h01, {6'b0, pair_operating_mode});
        wr(ADDR_RUN_CTRL, 8'h00);
        settle();
        chk("dbuf off", 8'h00, {7'b0, compare_double_buffer_en});
        $display("test mode done");
        pulse(4'h1);
        chk("irq set", 8'h01, {7'b0, irq});
        rd(ADDR_IRQ_STATUS, rv);
        chk("status", 8'h01, rv & 8'h0F);
        settle();
        chk("irq clr", 8'h00, {7'b0, irq});
        rd(ADDR_IRQ_STATUS, rv);
        chk("status again", 8'h00, rv & 8'h0F);
        wr(ADDR_IRQ_MASK, 8'h0A);
        rd(ADDR_IRQ_MASK, rv);
        chk("mask", 8'h0A, rv & 8'h0F);
        pulse(4'hA);
        chk("irq masked", 8'h00, {7'b0, irq});
        pulse(4'h4);
        chk("irq open", 8'h01, {7'b0, irq});
        wr(ADDR_IRQ_CLEAR, 8'h04);
        settle();
        chk("irq cleared", 8'h00, {7'b0, irq});
        rd(ADDR_IRQ_STATUS, rv);
        chk("status", 8'h0A, rv & 8'h0F);
        wr(ADDR_IRQ_MASK, 8'h0F);
        pulse(4'h1);
        chk("irq all masked", 8'h00, {7'b0, irq});
        // Event in the status read cycle must survive the clear
        fork
            rd(ADDR_IRQ_STATUS, rv);
            pulse(4'h2);
        join
        chk("status masked", 8'h01, rv & 8'h0F);
        rd(ADDR_IRQ_STATUS, rv);
        chk("status set wins", 8'h02, rv & 8'h0F);
        rd(32'hFFFF_F1FF, rv);
        chk("unmapped", 8'h00, rv);
        $display("test irq done");
        results();
    end
endmodule : tb
